/* File: bench/emhp_chk.sv */
`timescale 1ns/1ps
module emhp_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] ad_dev_oe,
    input wire logic [7:0] ad_host_oe,
    input wire logic host_addr_latch,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_low_tail(s);
        !s [*3] ##1 s;
    endsequence
    sequence s_latch_tail;
        host_addr_latch ##1 !host_addr_latch;
    endsequence
    a_latch_width: assert property (
        $rose(host_addr_latch) |=> s_latch_tail) else $error("latch pulse width wrong");
    a_read_width: assert property (
        $fell(host_read_strobe_n) |=> s_low_tail(host_read_strobe_n))
        else $error("read strobe width wrong");
    a_write_width: assert property (
        $fell(host_write_strobe_n) |=> s_low_tail(host_write_strobe_n))
        else $error("write strobe width wrong");
    a_strobes_exclusive: assert property (
        !(!host_read_strobe_n && !host_write_strobe_n)) else $error("both strobes low");
    a_strobe_after_latch: assert property (
        ($fell(host_read_strobe_n) || $fell(host_write_strobe_n)) |->
        !host_addr_latch && !$past(host_addr_latch)) else $error("strobe overlaps latch");
    a_write_host_drives: assert property (
        !host_write_strobe_n |-> ad_host_oe == 8'hFF) else $error("host not driving write data");
    a_read_host_quiet: assert property (
        !host_read_strobe_n |-> ad_host_oe == 8'h00) else $error("host drives during read");
    a_latch_addr_phase: assert property (
        host_addr_latch |-> ad_host_oe == 8'hFF && ad_dev_oe == 8'h00)
        else $error("address phase bus owner wrong");
    a_dev_needs_read: assert property (
        $rose(|ad_dev_oe) |-> !host_read_strobe_n) else $error("device drives without read");
    a_dev_whole_byte: assert property (
        ad_dev_oe == 8'h00 || ad_dev_oe == 8'hFF) else $error("partial byte drive");
endmodule : emhp_chk

/* File: bench/test_external_mcu_host_port.sv */
`timescale 1ns/1ps
module test_external_mcu_host_port;
    import emhp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic master_reset_n = 1'b1;
    logic bus_reset = 1'b0;
    logic external_proc_select = 1'b1;
    logic factory_test = 1'b0;
    logic [3:0] irq_src = 4'h0;
    logic ext_irq_in_n = 1'b1;
    logic pullup_enable = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [10:0] req_addr = 11'h000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, irq_seen, pullup_connect, embedded_irq_req, port_active;
    logic [7:0] rsp_rdata;
    logic [7:0] sb [0:2047];
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    emhp_if bus_if ();
    emhp_device emhp_device_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .master_reset_n(master_reset_n), .bus_reset(bus_reset),
        .external_proc_select(external_proc_select), .factory_test(factory_test),
        .irq_src(irq_src), .ext_irq_in_n(ext_irq_in_n), .pullup_enable(pullup_enable),
        .pullup_connect(pullup_connect), .embedded_irq_req(embedded_irq_req),
        .port_active(port_active));
    emhp_host emhp_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
    emhp_chk emhp_chk_inst (.clk(clk), .sys_rst(sys_rst), .ad_dev_oe(bus_if.ad_dev_oe),
        .ad_host_oe(bus_if.ad_host_oe), .host_addr_latch(bus_if.host_addr_latch),
        .host_read_strobe_n(bus_if.host_read_strobe_n),
        .host_write_strobe_n(bus_if.host_write_strobe_n));
    always #5 clk = ~clk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // Whole run is well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    function automatic logic exp_irq(input logic [3:0] s, input logic act);
        return act & (|s);
    endfunction : exp_irq
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        do @(negedge clk); while (req_ready !== 1'b1 && ++n < 40);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 40);
        chk(n < 40, "no response");
        q = rsp_rdata;
    endtask : xfer
    // Straps must sit still for several edges before reset lets go
    task automatic strap(input logic sel, input logic tst);
        @(posedge clk);
        external_proc_select <= sel;
        factory_test <= tst;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(negedge clk);
    endtask : strap
    initial begin
        logic [7:0] d;
        logic [7:0] q;
        logic [10:0] al[$];
        void'($urandom(32'h8CDAF645));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        al = '{11'h000, 11'h7FF, 11'h0AA, 11'h5AA};
        repeat (20) al.push_back(11'($urandom));
        foreach (al[i]) begin
            d = 8'($urandom);
            sb[al[i]] = d;
            xfer(1'b1, al[i], d, q);
        end
        foreach (al[i]) begin
            xfer(1'b0, al[i], 8'h00, q);
            chk(q === sb[al[i]], "read data");
        end
        $display("test memory done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            irq_src <= (i == 0) ? 4'h0 : 4'($urandom);
            ext_irq_in_n <= i[0];
            pullup_enable <= i[1];
            bus_reset <= i[2];
            repeat (6) @(negedge clk);
            chk(irq_seen === exp_irq(irq_src, 1'b1), "irq out");
            chk(embedded_irq_req === ~ext_irq_in_n, "ext irq");
            chk(pullup_connect === pullup_enable, "pullup");
            chk(bus_if.reset_follow_out === bus_reset, "reset out");
        end
        bus_reset <= 1'b0;
        $display("test side signals done");
        strap(1'b1, 1'b1);
        chk(port_active === 1'b0 && irq_seen === exp_irq(irq_src, 1'b0), "test strap");
        strap(1'b0, 1'b0);
        chk(port_active === 1'b0, "internal strap");
        xfer(1'b1, 11'h000, ~sb[0], q);
        xfer(1'b0, 11'h000, 8'h00, q);
        chk(q === 8'h00, "inactive read");
        strap(1'b1, 1'b0);
        xfer(1'b0, 11'h000, 8'h00, q);
        chk(q === sb[0] && port_active === 1'b1, "write ignored");
        $display("test straps done");
        @(posedge clk);
        master_reset_n <= 1'b0;
        #1;
        chk(bus_if.reset_follow_out === 1'b1 && port_active === 1'b0, "async reset");
        chk(pullup_connect === 1'b0 && bus_if.host_irq_out === 1'b0, "reset outputs");
        repeat (3) @(posedge clk);
        master_reset_n <= 1'b1;
        repeat (8) @(negedge clk);
        chk(bus_if.reset_follow_out === 1'b0 && port_active === 1'b1, "reset release");
        xfer(1'b1, 11'h3C5, 8'hA7, q);
        xfer(1'b0, 11'h3C5, 8'h00, q);
        chk(q === 8'hA7, "after reset");
        $display("test master reset done");
        complete_run();
    end
endmodule : test_external_mcu_host_port

/* File: design/emhp_device.sv */
`timescale 1ns/1ps
// Functional notes
// - Eight shared lines carry address then data
// - Host drives address bits eight to ten
// - Address latch enable captures low address byte
// - Read strobe makes device drive stored byte
// - Write strobe stores bus byte at address
// - Interrupt output is OR of sources, held low while port inactive
// - Low master reset asynchronously resets logic
// - Reset output follows master or bus reset
// - Device drives pull-up connect control
// - Low external interrupt raises embedded request
// - Port active only if select high, test low
module emhp_device #(
    parameter int NUM_IRQ = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    emhp_if.dev bus,
    input wire logic master_reset_n,
    input wire logic bus_reset,
    input wire logic external_proc_select,
    input wire logic factory_test,
    input wire logic [NUM_IRQ-1:0] irq_src,
    input wire logic ext_irq_in_n,
    input wire logic pullup_enable,
    output logic pullup_connect,
    output logic embedded_irq_req,
    output logic port_active
);
    import emhp_pkg::*;

    logic [1:0] mrst_sync_ff;
    logic arst_n;

    // Pin synchronisers, two flops each
    logic [1:0] ale_sync_ff;
    logic [1:0] rd_sync_ff;
    logic [1:0] wr_sync_ff;
    logic [1:0] ext_irq_in_n_sync_ff;
    logic [1:0] sel_sync_ff;
    logic [1:0] test_sync_ff;
    wire logic [EMHP_DATA_W-1:0] ad_sync;
    logic [EMHP_HIGH_W-1:0] hi_s1_ff;
    logic [EMHP_HIGH_W-1:0] hi_s2_ff;

    // Host access state
    logic ale_d_ff;
    logic wr_d_ff;
    logic released_ff;
    logic port_active_ff;
    logic [EMHP_LOW_W-1:0] low_addr_ff;
    logic [EMHP_ADDR_W-1:0] addr;
    // Memory has no reset: a byte never written reads back unknown
    logic [EMHP_DATA_W-1:0] mem [EMHP_MEM_DEPTH];
    logic [EMHP_DATA_W-1:0] rd_data_ff;
    logic [7:0] ad_oe_ff;

    // Side-band outputs
    logic irq_ff;
    logic reset_follow_out_ff;
    logic pur_ff;
    logic xirq_ff;

    // Async assert, synchronous release of the master reset
    assign arst_n = mrst_sync_ff[1];
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            mrst_sync_ff <= 2'b00;
        end else begin
            mrst_sync_ff <= {mrst_sync_ff[0], 1'b1};
        end
    end

    // Pin inputs through two flops before any logic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ale_sync_ff <= 2'b00;
            rd_sync_ff <= 2'b11;
            wr_sync_ff <= 2'b11;
            ext_irq_in_n_sync_ff <= 2'b11;
            hi_s1_ff <= 3'h0;
            hi_s2_ff <= 3'h0;
        end else begin
            ale_sync_ff <= {ale_sync_ff[0], bus.host_addr_latch};
            rd_sync_ff <= {rd_sync_ff[0], bus.host_read_strobe_n};
            wr_sync_ff <= {wr_sync_ff[0], bus.host_write_strobe_n};
            ext_irq_in_n_sync_ff <= {ext_irq_in_n_sync_ff[0], ext_irq_in_n};
            hi_s1_ff <= bus.high_addr_line;
            hi_s2_ff <= hi_s1_ff;
        end
    end

    // Straps keep sampling through master reset, so the value taken at release is settled
    always_ff @(posedge clk) begin
        sel_sync_ff <= {sel_sync_ff[0], external_proc_select};
        test_sync_ff <= {test_sync_ff[0], factory_test};
    end

    // One synchroniser per address/data bit; the host holds the bus for several
    // cycles around each latch falling edge and write strobe rising edge, so no bit straddles a change
    for (genvar gi = 0; gi < EMHP_DATA_W; gi++) begin : g_ad_sync
        logic [1:0] bit_sync_ff;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                bit_sync_ff <= 2'b00;
            end else begin
                bit_sync_ff <= {bit_sync_ff[0], bus.shared_addr_data_line[gi]};
            end
        end
        assign ad_sync[gi] = bit_sync_ff[1];
    end

    // Mode strap taken once, the first cycle after reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            released_ff <= 1'b0;
            port_active_ff <= 1'b0;
        end else if (sys_rst) begin
            released_ff <= 1'b0;
            port_active_ff <= 1'b0;
        // A strap change after this point waits for the next reset
        end else if (!released_ff) begin
            released_ff <= 1'b1;
            port_active_ff <= (sel_sync_ff[1] == EMHP_SEL_EXT) &&
                (test_sync_ff[1] == EMHP_TEST_OFF);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ale_d_ff <= 1'b0;
            wr_d_ff <= 1'b1;
            low_addr_ff <= 8'h00;
        end else if (sys_rst) begin
            ale_d_ff <= 1'b0;
            wr_d_ff <= 1'b1;
            low_addr_ff <= 8'h00;
        end else begin
            ale_d_ff <= ale_sync_ff[1];
            wr_d_ff <= wr_sync_ff[1];
            // Bus sampled with the same lag as the latch, so the byte is the address
            if (ale_d_ff && !ale_sync_ff[1]) begin
                low_addr_ff <= ad_sync;
            end
        end
    end

    assign addr = {hi_s2_ff, low_addr_ff};

    // Write on the strobe's rising edge, when data has long been stable
    always_ff @(posedge clk) begin
        if (port_active_ff && !wr_d_ff && wr_sync_ff[1] && rd_sync_ff[1]) begin
            mem[addr] <= ad_sync;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_ff <= EMHP_MEM_RST;
            ad_oe_ff <= 8'h00;
        end else if (sys_rst) begin
            rd_data_ff <= EMHP_MEM_RST;
            ad_oe_ff <= 8'h00;
        end else begin
            // Refreshed every cycle from the latched address, so the byte is ready
            // well before the bus is turned round toward the host
            rd_data_ff <= mem[addr];
            // Drive only while read is low and write idle, never during address phase
            ad_oe_ff <= (port_active_ff && !rd_sync_ff[1] && wr_sync_ff[1] &&
                !ale_sync_ff[1]) ? 8'hFF : 8'h00;
        end
    end
    assign bus.ad_dev_o = rd_data_ff;
    assign bus.ad_dev_oe = ad_oe_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_ff <= 1'b0;
            xirq_ff <= 1'b0;
            pur_ff <= 1'b0;
        end else if (sys_rst) begin
            irq_ff <= 1'b0;
            xirq_ff <= 1'b0;
            pur_ff <= 1'b0;
        end else begin
            irq_ff <= port_active_ff && (|irq_src);
            xirq_ff <= !ext_irq_in_n_sync_ff[1];
            pur_ff <= pullup_enable;
        end
    end

    // Reset output asserts at once with master reset, not after the synchroniser
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            reset_follow_out_ff <= 1'b1;
        end else begin
            reset_follow_out_ff <= !arst_n || bus_reset;
        end
    end

    assign bus.host_irq_out = irq_ff;
    assign bus.reset_follow_out = reset_follow_out_ff;
    assign pullup_connect = pur_ff;
    assign embedded_irq_req = xirq_ff;
    assign port_active = port_active_ff;
endmodule : emhp_device

/* File: design/emhp_host.sv */
`timescale 1ns/1ps
module emhp_host (
    input wire logic clk,
    input wire logic sys_rst,
    emhp_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [emhp_pkg::EMHP_ADDR_W-1:0] req_addr,
    input wire logic [emhp_pkg::EMHP_DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [emhp_pkg::EMHP_DATA_W-1:0] rsp_rdata,
    output logic irq_seen
);
    import emhp_pkg::*;

    emhp_hstate_t state_ff;
    logic [EMHP_CNT_W-1:0] cnt_ff;
    logic wr_ff, ale_ff, rd_n_ff, wr_n_ff, ready_ff, rsp_ff;
    logic [EMHP_ADDR_W-1:0] addr_ff;
    logic [7:0] wdata_ff, ad_o_ff, ad_oe_ff, rdata_ff;
    logic [1:0] irq_sync_ff;
    logic [7:0] ad_s1_ff, ad_s2_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_sync_ff <= 2'b00;
            ad_s1_ff <= 8'h00;
            ad_s2_ff <= 8'h00;
        end else begin
            irq_sync_ff <= {irq_sync_ff[0], bus.host_irq_out};
            ad_s1_ff <= bus.shared_addr_data_line;
            ad_s2_ff <= ad_s1_ff;
        end
    end

    // Address phase, gap, then one active-low strobe at a time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= EMHP_H_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 8'h00;
            ale_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            ad_o_ff <= 8'h00;
            ad_oe_ff <= 8'h00;
            ready_ff <= 1'b0;
            rsp_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            rsp_ff <= 1'b0;
            case (state_ff)
                EMHP_H_IDLE: begin
                    ready_ff <= 1'b1;
                    if (req_valid && ready_ff) begin
                        ready_ff <= 1'b0;
                        wr_ff <= req_write;
                        addr_ff <= req_addr;
                        wdata_ff <= req_wdata;
                        ale_ff <= 1'b1;
                        ad_o_ff <= req_addr[7:0];
                        ad_oe_ff <= 8'hFF;
                        cnt_ff <= EMHP_CNT_W'(EMHP_ALE_CYC - 1);
                        state_ff <= EMHP_H_ALE;
                    end
                end
                EMHP_H_ALE: begin
                    if (cnt_ff == '0) begin
                        ale_ff <= 1'b0;
                        cnt_ff <= EMHP_CNT_W'(EMHP_GAP_CYC - 1);
                        state_ff <= EMHP_H_GAP;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                EMHP_H_GAP: begin
                    if (cnt_ff == '0) begin
                        ad_o_ff <= wdata_ff;
                        ad_oe_ff <= wr_ff ? 8'hFF : 8'h00;
                        rd_n_ff <= wr_ff;
                        wr_n_ff <= !wr_ff;
                        cnt_ff <= EMHP_CNT_W'(EMHP_STB_CYC - 1);
                        state_ff <= EMHP_H_STB;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                EMHP_H_STB: begin
                    if (cnt_ff == '0) begin
                        rd_n_ff <= 1'b1;
                        wr_n_ff <= 1'b1;
                        cnt_ff <= EMHP_CNT_W'(EMHP_GAP_CYC - 1);
                        state_ff <= EMHP_H_END;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                EMHP_H_END: begin
                    // Hold write data past the strobe edge so the device samples it stable
                    // Device drive appears three edges into the strobe and our synchroniser
                    // adds two more, so read data is only settled here, not at strobe end
                    if (cnt_ff == '0) begin
                        rdata_ff <= ad_s2_ff;
                        ad_oe_ff <= 8'h00;
                        rsp_ff <= 1'b1;
                        state_ff <= EMHP_H_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: state_ff <= EMHP_H_IDLE;
            endcase
        end
    end

    assign bus.ad_host_o = ad_o_ff;
    assign bus.ad_host_oe = ad_oe_ff;
    assign bus.high_addr_line = addr_ff[EMHP_ADDR_W-1:EMHP_LOW_W];
    assign bus.host_addr_latch = ale_ff;
    assign bus.host_read_strobe_n = rd_n_ff;
    assign bus.host_write_strobe_n = wr_n_ff;
    assign req_ready = ready_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rdata_ff;
    assign irq_seen = irq_sync_ff[1];
endmodule : emhp_host

/* File: design/emhp_if.sv */
`timescale 1ns/1ps
interface emhp_if;
    logic [7:0] ad_dev_o;
    logic [7:0] ad_dev_oe;
    logic [7:0] ad_host_o;
    logic [7:0] ad_host_oe;
    logic [7:0] shared_addr_data_line;
    logic [2:0] high_addr_line;
    logic host_addr_latch;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic host_irq_out;
    logic reset_follow_out;
    // Resolved multiplexed bus; both-driven bits read as device data
    assign shared_addr_data_line = (ad_dev_oe & ad_dev_o) | (~ad_dev_oe & ad_host_oe & ad_host_o);
    modport dev (
        input shared_addr_data_line, high_addr_line, host_addr_latch,
        input host_read_strobe_n, host_write_strobe_n,
        output ad_dev_o, ad_dev_oe, host_irq_out, reset_follow_out
    );
    modport host (
        input shared_addr_data_line, host_irq_out, reset_follow_out,
        output ad_host_o, ad_host_oe, high_addr_line, host_addr_latch,
        output host_read_strobe_n, host_write_strobe_n
    );
endinterface : emhp_if

/* File: design/emhp_pkg.sv */
package emhp_pkg;
    localparam int EMHP_ADDR_W = 11;
    localparam int EMHP_DATA_W = 8;
    localparam int EMHP_LOW_W = 8;
    localparam int EMHP_HIGH_W = 3;
    localparam int EMHP_MEM_DEPTH = 2048;
    localparam logic [7:0] EMHP_MEM_RST = 8'h00;
    localparam logic EMHP_SEL_EXT = 1'b1;
    localparam logic EMHP_TEST_OFF = 1'b0;
    // Host strobe widths, in clock cycles
    localparam int EMHP_ALE_CYC = 2;
    localparam int EMHP_STB_CYC = 4;
    localparam int EMHP_GAP_CYC = 2;
    localparam int EMHP_CNT_W = 4;
    typedef enum logic [4:0] {
        EMHP_H_IDLE = 5'b00001,
        EMHP_H_ALE = 5'b00010,
        EMHP_H_GAP = 5'b00100,
        EMHP_H_STB = 5'b01000,
        EMHP_H_END = 5'b10000
    } emhp_hstate_t;
endpackage : emhp_pkg
